// ---- dag_pkg.sv ----
package dag_pkg;
    // ------------------------------------------------------------
    // widths and field positions
    // ------------------------------------------------------------
    localparam int ADDR_W        = 16;
    localparam int PAGE_W        = 8;
    localparam int FULL_W        = 24;
    localparam int IMM_W         = 8;
    localparam int NUM_IDX       = 4;
    localparam int SEL_W         = 2;
    localparam int BIT_REV_POS   = 1;
    localparam int MODE_W        = 16;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [PAGE_W-1:0] PAGE_RST = 8'h00;
    localparam logic [ADDR_W-1:0] REG_RST  = 16'h0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DAG_OP_NONE,
        DAG_OP_PRE,
        DAG_OP_POST
    } dag_op_t;

    typedef enum logic [2:0] {
        DAG_WR_NONE,
        DAG_WR_INDEX,
        DAG_WR_MODIFY,
        DAG_WR_LENGTH,
        DAG_WR_BASE,
        DAG_WR_PAGE
    } dag_wr_t;
endpackage : dag_pkg

// ---- dag_req_if.sv ----
`timescale 1ns/10ps
interface dag_req_if;
    dag_pkg::dag_op_t                  op;
    logic [dag_pkg::SEL_W-1:0]         idx_sel;
    logic [dag_pkg::SEL_W-1:0]         mod_sel;
    logic                              use_imm;
    logic [dag_pkg::IMM_W-1:0]         imm;
    logic                              multifunc;
    logic                              rev_en;
    dag_pkg::dag_wr_t                  wr_kind;
    logic [dag_pkg::SEL_W-1:0]         wr_sel;
    logic [dag_pkg::ADDR_W-1:0]        wr_data;
    logic [dag_pkg::FULL_W-1:0]        addr;
    logic                              addr_valid;

    modport core (output op, idx_sel, mod_sel, use_imm, imm, multifunc, rev_en,
                  output wr_kind, wr_sel, wr_data, input addr, addr_valid);
    modport unit (input op, idx_sel, mod_sel, use_imm, imm, multifunc, rev_en,
                  input wr_kind, wr_sel, wr_data, output addr, addr_valid);
endinterface : dag_req_if

// ---- dag_unit.sv ----
`timescale 1ns/10ps
module dag_unit #(
    parameter bit REV_CAPABLE = 1'b0
) (
    input  wire logic  clock,
    input  wire logic  rst_n,
    dag_req_if.unit    rq
);
    localparam int AW = dag_pkg::ADDR_W;

    logic [AW-1:0]             index_ff  [dag_pkg::NUM_IDX];
    logic [AW-1:0]             modify_ff [dag_pkg::NUM_IDX];
    logic [AW-1:0]             length_ff [dag_pkg::NUM_IDX];
    logic [AW-1:0]             base_ff   [dag_pkg::NUM_IDX];
    logic [dag_pkg::PAGE_W-1:0] page_ff;
    logic [dag_pkg::FULL_W-1:0] addr_ff;
    logic                      addr_valid_ff;
    logic [AW-1:0]             cur_i;
    logic [AW-1:0]             modv;
    logic [AW-1:0]             sum;
    logic [AW-1:0]             nxt_index;
    logic [AW-1:0]             out_lo;
    logic [AW:0]               end_ext;
    logic [AW:0]               sum_ext;
    logic                      mneg;
    logic                      circ;

    function automatic logic [AW-1:0] bit_mirror(input logic [AW-1:0] v);
        logic [AW-1:0] r;
        r = '0;
        for (int k = 0; k < AW; k++) begin
            r[k] = v[AW-1-k];
        end
        return r;
    endfunction : bit_mirror

    // ------------------------------------------------------------
    // modifier selection and arithmetic
    // ------------------------------------------------------------
    always_comb begin
        cur_i = index_ff[rq.idx_sel];
        // immediate refused in multifunction form, register used instead
        if (rq.use_imm && !rq.multifunc) begin
            modv = {{(AW-dag_pkg::IMM_W){rq.imm[dag_pkg::IMM_W-1]}}, rq.imm};
        end else begin
            modv = modify_ff[rq.mod_sel];
        end
        mneg    = modv[AW-1];
        sum     = cur_i + modv;
        sum_ext = {1'b0, cur_i} + {1'b0, modv} - (mneg ? 17'h10000 : 17'h00000);
        end_ext = {1'b0, base_ff[rq.idx_sel]} + {1'b0, length_ff[rq.idx_sel]};
        circ    = (length_ff[rq.idx_sel] != '0);
        nxt_index = sum;
        // wrap compare is done in 17 bits so an end past 0xFFFF still works
        if (circ && !mneg && (sum_ext >= end_ext)) begin
            nxt_index = sum - length_ff[rq.idx_sel];
        end else if (circ && mneg && (sum_ext[AW] || sum < base_ff[rq.idx_sel])) begin
            nxt_index = sum + length_ff[rq.idx_sel];
        end
        out_lo = (rq.op == dag_pkg::DAG_OP_PRE) ? sum : cur_i;
        if (REV_CAPABLE && rq.rev_en) begin
            out_lo = bit_mirror(out_lo);
        end
    end

    // ------------------------------------------------------------
    // index registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int k = 0; k < dag_pkg::NUM_IDX; k++) begin
                index_ff[k] <= dag_pkg::REG_RST;
            end
        end else if (rq.op == dag_pkg::DAG_OP_POST) begin
            index_ff[rq.idx_sel] <= nxt_index;
        end else if (rq.wr_kind == dag_pkg::DAG_WR_INDEX) begin
            index_ff[rq.wr_sel] <= rq.wr_data;
        end
    end

    // ------------------------------------------------------------
    // modify, length, base and page registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int k = 0; k < dag_pkg::NUM_IDX; k++) begin
                modify_ff[k] <= dag_pkg::REG_RST;
                length_ff[k] <= dag_pkg::REG_RST;
                base_ff[k]   <= dag_pkg::REG_RST;
            end
            page_ff <= dag_pkg::PAGE_RST;
        end else begin
            unique case (rq.wr_kind)
                dag_pkg::DAG_WR_MODIFY: modify_ff[rq.wr_sel] <= rq.wr_data;
                dag_pkg::DAG_WR_LENGTH: length_ff[rq.wr_sel] <= rq.wr_data;
                dag_pkg::DAG_WR_BASE:   base_ff[rq.wr_sel]   <= rq.wr_data;
                dag_pkg::DAG_WR_PAGE:   page_ff <= rq.wr_data[dag_pkg::PAGE_W-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // address output
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            addr_ff       <= '0;
            addr_valid_ff <= 1'b0;
        end else begin
            addr_valid_ff <= (rq.op != dag_pkg::DAG_OP_NONE);
            if (rq.op != dag_pkg::DAG_OP_NONE) begin
                addr_ff <= {page_ff, out_lo};
            end
        end
    end

    assign rq.addr       = addr_ff;
    assign rq.addr_valid = addr_valid_ff;

    chk_pre_keeps_index: assert property (@(posedge clock) disable iff (!rst_n)
        (rq.op == dag_pkg::DAG_OP_PRE && rq.wr_kind == dag_pkg::DAG_WR_NONE)
        |=> index_ff[$past(rq.idx_sel)] == $past(cur_i))
        else $error("pre-modify changed index");
    chk_page_on_top: assert property (@(posedge clock) disable iff (!rst_n)
        (rq.op != dag_pkg::DAG_OP_NONE && rq.wr_kind != dag_pkg::DAG_WR_PAGE)
        |=> rq.addr[dag_pkg::FULL_W-1:AW] == page_ff)
        else $error("page bits wrong");
    chk_linear_step: assert property (@(posedge clock) disable iff (!rst_n)
        (rq.op == dag_pkg::DAG_OP_POST && !circ)
        |=> index_ff[$past(rq.idx_sel)] == $past(cur_i) + $past(modv))
        else $error("linear update wrong");
    chk_post_out_index: assert property (@(posedge clock) disable iff (!rst_n)
        (rq.op == dag_pkg::DAG_OP_POST && !(REV_CAPABLE && rq.rev_en))
        |=> rq.addr[AW-1:0] == $past(cur_i))
        else $error("post-modify output not old index");
    chk_circ_in_range: assert property (@(posedge clock) disable iff (!rst_n)
        (rq.op == dag_pkg::DAG_OP_POST && circ && !mneg
         && cur_i >= base_ff[rq.idx_sel] && {1'b0, cur_i} < end_ext)
        |=> {1'b0, index_ff[$past(rq.idx_sel)]} < $past(end_ext))
        else $error("circular index left buffer");
    chk_no_rev_second: assert property (@(posedge clock) disable iff (!rst_n)
        (!REV_CAPABLE && rq.op == dag_pkg::DAG_OP_PRE)
        |=> rq.addr[AW-1:0] == $past(sum))
        else $error("second unit reversed");
endmodule : dag_unit

// ---- dag_top.sv ----
`timescale 1ns/10ps
// How it works
// - every output address carries the unit's page register on top
// - pre-modify outputs index plus modifier, index untouched
// - post-modify outputs index, then stores index plus modifier
// - any modify register pairs with any index of the same unit
// - single access modifier is modify register or signed 8-bit immediate
// - multifunction accesses use only a modify register
// - arithmetic never carries into the page bits
// - circular post-modify subtracts or adds length when leaving the buffer
// - circular wrap only on post-modify
// - zero length means linear modification
// - any base value is accepted
// - only the first unit can reverse address bits
// - both units work independently in the same cycle
// - mode bit 1 enables reversal for the first unit
// - page gives upper 8 bits of a 24-bit address
// - reversal affects output only, stored index stays normal
// - full reversal mirrors all 16 bits
module dag_top (
    input  wire logic                           clock,
    input  wire logic                           rst_n,
    input  wire logic [dag_pkg::MODE_W-1:0]     mode_status_register,
    input  wire dag_pkg::dag_op_t               a_op,
    input  wire logic [dag_pkg::SEL_W-1:0]      a_idx_sel,
    input  wire logic [dag_pkg::SEL_W-1:0]      a_mod_sel,
    input  wire logic                           a_use_imm,
    input  wire logic [dag_pkg::IMM_W-1:0]      a_imm,
    input  wire logic                           a_multifunc,
    input  wire dag_pkg::dag_wr_t               a_wr_kind,
    input  wire logic [dag_pkg::SEL_W-1:0]      a_wr_sel,
    input  wire logic [dag_pkg::ADDR_W-1:0]     a_wr_data,
    output wire logic [dag_pkg::FULL_W-1:0]     a_addr,
    output wire logic                           a_addr_valid,
    input  wire dag_pkg::dag_op_t               b_op,
    input  wire logic [dag_pkg::SEL_W-1:0]      b_idx_sel,
    input  wire logic [dag_pkg::SEL_W-1:0]      b_mod_sel,
    input  wire logic                           b_use_imm,
    input  wire logic [dag_pkg::IMM_W-1:0]      b_imm,
    input  wire logic                           b_multifunc,
    input  wire dag_pkg::dag_wr_t               b_wr_kind,
    input  wire logic [dag_pkg::SEL_W-1:0]      b_wr_sel,
    input  wire logic [dag_pkg::ADDR_W-1:0]     b_wr_data,
    output wire logic [dag_pkg::FULL_W-1:0]     b_addr,
    output wire logic                           b_addr_valid
);
    // ------------------------------------------------------------
    // first_address_unit: reversal capable
    // ------------------------------------------------------------
    dag_req_if first_rq ();
    assign first_rq.op        = a_op;
    assign first_rq.idx_sel   = a_idx_sel;
    assign first_rq.mod_sel   = a_mod_sel;
    assign first_rq.use_imm   = a_use_imm;
    assign first_rq.imm       = a_imm;
    assign first_rq.multifunc = a_multifunc;
    assign first_rq.rev_en    = mode_status_register[dag_pkg::BIT_REV_POS];
    assign first_rq.wr_kind   = a_wr_kind;
    assign first_rq.wr_sel    = a_wr_sel;
    assign first_rq.wr_data   = a_wr_data;
    assign a_addr             = first_rq.addr;
    assign a_addr_valid       = first_rq.addr_valid;

    dag_unit #(.REV_CAPABLE(1'b1)) u_first (
        .clock (clock),
        .rst_n (rst_n),
        .rq    (first_rq)
    );

    // ------------------------------------------------------------
    // second_address_unit: normal order only, runs alongside
    // ------------------------------------------------------------
    dag_req_if second_rq ();
    assign second_rq.op        = b_op;
    assign second_rq.idx_sel   = b_idx_sel;
    assign second_rq.mod_sel   = b_mod_sel;
    assign second_rq.use_imm   = b_use_imm;
    assign second_rq.imm       = b_imm;
    assign second_rq.multifunc = b_multifunc;
    assign second_rq.rev_en    = 1'b0;
    assign second_rq.wr_kind   = b_wr_kind;
    assign second_rq.wr_sel    = b_wr_sel;
    assign second_rq.wr_data   = b_wr_data;
    assign b_addr              = second_rq.addr;
    assign b_addr_valid        = second_rq.addr_valid;

    dag_unit #(.REV_CAPABLE(1'b0)) u_second (
        .clock (clock),
        .rst_n (rst_n),
        .rq    (second_rq)
    );

    chk_both_concurrent: assert property (@(posedge clock) disable iff (!rst_n)
        (a_op != dag_pkg::DAG_OP_NONE && b_op != dag_pkg::DAG_OP_NONE)
        |=> a_addr_valid && b_addr_valid)
        else $error("units not concurrent");
    chk_rev_mirror: assert property (@(posedge clock) disable iff (!rst_n)
        (a_op == dag_pkg::DAG_OP_POST && mode_status_register[dag_pkg::BIT_REV_POS])
        |=> a_addr[0] == $past(u_first.cur_i[15]) && a_addr[8] == $past(u_first.cur_i[7]))
        else $error("reversal wrong");
endmodule : dag_top

// ---- dag_bus_sink.sv ----
`timescale 1ns/10ps
module dag_bus_sink (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic addr_valid,
    output int        seen
);
    // ------------------------------------------------------------
    // memory side: counts every address strobe of one unit
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            seen <= 0;
        end else if (addr_valid) begin
            seen <= seen + 1;
        end
    end
endmodule : dag_bus_sink

// ---- tb.sv ----
`timescale 1ns/10ps
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin miscompares++; $display("mismatch %0t %s", $time, m); end end
module tb;
    typedef struct packed {
        dag_pkg::dag_op_t op;
        logic [1:0]       idx;
        logic [1:0]       mods;
        logic             imm_on;
        logic [7:0]       imm;
        logic             mf;
        dag_pkg::dag_wr_t wk;
        logic [1:0]       ws;
        logic [15:0]      wd;
    } dag_rq_t;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] mode  = 16'h0000;
    dag_rq_t     rq [2] = '{default: '0};
    logic [23:0] addr [2];
    logic        vld [2];
    logic [15:0] mi [2][4], mm [2][4], ml [2][4], mb [2][4];
    logic [7:0]  mp [2] = '{default: '0};
    logic [23:0] exp_addr [2] = '{default: '0};
    logic        exp_v [2] = '{default: 1'b0};
    int          miscompares = 0, checks = 0, n_acc [2] = '{0, 0}, seen [2];
    always #10 clock = ~clock;
    dag_top u_dut (.clock(clock), .rst_n(rst_n), .mode_status_register(mode),
        .a_op(rq[0].op), .a_idx_sel(rq[0].idx), .a_mod_sel(rq[0].mods), .a_use_imm(rq[0].imm_on),
        .a_imm(rq[0].imm), .a_multifunc(rq[0].mf), .a_wr_kind(rq[0].wk), .a_wr_sel(rq[0].ws),
        .a_wr_data(rq[0].wd), .a_addr(addr[0]), .a_addr_valid(vld[0]),
        .b_op(rq[1].op), .b_idx_sel(rq[1].idx), .b_mod_sel(rq[1].mods), .b_use_imm(rq[1].imm_on),
        .b_imm(rq[1].imm), .b_multifunc(rq[1].mf), .b_wr_kind(rq[1].wk), .b_wr_sel(rq[1].ws),
        .b_wr_data(rq[1].wd), .b_addr(addr[1]), .b_addr_valid(vld[1]));
    dag_bus_sink u_sink_a (.clock(clock), .rst_n(rst_n), .addr_valid(vld[0]), .seen(seen[0]));
    dag_bus_sink u_sink_b (.clock(clock), .rst_n(rst_n), .addr_valid(vld[1]), .seen(seen[1]));
    // ------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------
    function automatic logic [15:0] rev16(input logic [15:0] v);
        for (int k = 0; k < 16; k++) rev16[k] = v[15-k];
    endfunction : rev16
    // access uses the state before this cycle's load, as a load shows one cycle later
    task automatic model(input int u, input dag_rq_t r, input logic [15:0] md);
        logic [15:0] m, o;
        int          t;
        m = (r.imm_on && !r.mf) ? {{8{r.imm[7]}}, r.imm} : mm[u][r.mods];
        o = (r.op == dag_pkg::DAG_OP_PRE) ? mi[u][r.idx] + m : mi[u][r.idx];
        if (u == 0 && md[1]) o = rev16(o);
        exp_v[u] = (r.op != dag_pkg::DAG_OP_NONE);
        if (exp_v[u]) exp_addr[u] = {mp[u], o};
        if (exp_v[u]) n_acc[u]++;
        if (r.op == dag_pkg::DAG_OP_POST) begin
            t = int'(mi[u][r.idx]) + (m[15] ? int'(m) - 65536 : int'(m));
            if (ml[u][r.idx] != 0 && !m[15] && t >= int'(mb[u][r.idx]) + int'(ml[u][r.idx])) t -= ml[u][r.idx];
            else if (ml[u][r.idx] != 0 && m[15] && t < int'(mb[u][r.idx])) t += ml[u][r.idx];
            mi[u][r.idx] = t[15:0];
        end
        case (r.wk)
            // a post-modify in the same cycle wins, the index load is lost
            dag_pkg::DAG_WR_INDEX:  if (r.op != dag_pkg::DAG_OP_POST) mi[u][r.ws] = r.wd;
            dag_pkg::DAG_WR_MODIFY: mm[u][r.ws] = r.wd;
            dag_pkg::DAG_WR_LENGTH: ml[u][r.ws] = r.wd;
            dag_pkg::DAG_WR_BASE:   mb[u][r.ws] = r.wd;
            dag_pkg::DAG_WR_PAGE:   mp[u] = r.wd[7:0];
            default: ;
        endcase
    endtask : model
    // drives both units at once and checks the answer to the previous cycle
    task automatic issue(input dag_rq_t r0, input dag_rq_t r1, input logic [15:0] md);
        @(posedge clock);
        rq[0] <= r0;
        rq[1] <= r1;
        mode  <= md;
        #1;
        `CHK(vld[0], exp_v[0], "unit a strobe")
        `CHK(vld[1], exp_v[1], "unit b strobe")
        `CHK(addr[0], exp_addr[0], "unit a address")
        `CHK(addr[1], exp_addr[1], "unit b address")
        model(0, r0, md);
        model(1, r1, md);
    endtask : issue
    function automatic dag_rq_t ld(input dag_pkg::dag_wr_t k, input int s, input logic [15:0] d);
        ld = '0;
        ld.wk = k;
        ld.ws = s[1:0];
        ld.wd = d;
    endfunction : ld
    function automatic dag_rq_t acc(input dag_pkg::dag_op_t o, input int i, input logic [7:0] im);
        acc = '0;
        acc.op = o;
        acc.idx = i[1:0];
        acc.mods = 2'($urandom_range(3));
        acc.imm_on = $urandom_range(1);
        acc.mf = $urandom_range(1);
        acc.imm = im;
    endfunction : acc
    // corner accesses force the immediate on, so the multifunction flag alone picks the modifier
    function automatic dag_rq_t acc_imm(input dag_pkg::dag_op_t o, input int i, input logic [7:0] im,
                                        input logic mfv);
        acc_imm = acc(o, i, im);
        acc_imm.imm_on = 1'b1;
        acc_imm.mf = mfv;
    endfunction : acc_imm
    task automatic end_sim;
        $display("counts: checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    // buffers stay in one page, lengths 32..63 keep every step of +-31 legal
    task automatic setup(input int u_only);
        dag_rq_t     r [2];
        logic [15:0] v [2][4][4];
        for (int u = 0; u < 2; u++) for (int s = 0; s < 4; s++) begin
            v[u][s][3] = 16'($urandom_range(16'hFF00));
            v[u][s][2] = $urandom_range(1) ? 16'($urandom_range(63, 32)) : 16'h0000;
            v[u][s][0] = v[u][s][2] != 0 ? v[u][s][3] + 16'($urandom % v[u][s][2]) : 16'($urandom);
            v[u][s][1] = 16'($urandom_range(62)) - 16'h001F;
        end
        for (int u = 0; u < 2; u++) r[u] = ld(dag_pkg::DAG_WR_PAGE, 0, 16'($urandom));
        issue(r[0], r[1], mode);
        for (int s = 0; s < 4; s++) for (int k = 0; k < 4; k++) begin
            for (int u = 0; u < 2; u++) r[u] = ld(dag_pkg::dag_wr_t'(k + 1), s, v[u][s][k]);
            issue(r[0], r[1], mode);
        end
    endtask : setup
    initial begin
        repeat (60000) @(posedge clock);
        miscompares++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h4604));
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        for (int round = 0; round < 6; round++) begin
            setup(0);
            for (int c = 0; c < 150; c++) begin
                issue(acc(dag_pkg::dag_op_t'($urandom_range(2)), $urandom_range(3), 8'($urandom_range(62)) - 8'h1F),
                      acc(dag_pkg::dag_op_t'($urandom_range(2)), $urandom_range(3), 8'($urandom_range(62)) - 8'h1F),
                      16'($urandom_range(1) << 1));
            end
            $display("test random round %0d done", round);
        end
        // carry out of the in-page part and extreme immediates on linear buffers
        issue(ld(dag_pkg::DAG_WR_LENGTH, 2, 16'h0000), ld(dag_pkg::DAG_WR_LENGTH, 2, 16'h0000), 16'h0002);
        issue(ld(dag_pkg::DAG_WR_INDEX, 2, 16'hFFFF), ld(dag_pkg::DAG_WR_INDEX, 2, 16'h0004), 16'h0002);
        issue(ld(dag_pkg::DAG_WR_PAGE, 0, 16'h005A), ld(dag_pkg::DAG_WR_PAGE, 0, 16'h00A5), 16'h0002);
        for (int k = 0; k < 4; k++) begin
            issue(acc_imm(dag_pkg::DAG_OP_PRE, 2, k[0] ? 8'h80 : 8'h7F, k[1]),
                  acc_imm(dag_pkg::DAG_OP_POST, 2, 8'h80, 1'b0), 16'h0002);
            issue(acc_imm(dag_pkg::DAG_OP_POST, 2, 8'h01, 1'b0),
                  acc_imm(dag_pkg::DAG_OP_PRE, 2, 8'h7F, 1'b0), 16'h0000);
        end
        $display("test page carry done");
        issue('0, '0, 16'h0000);
        // the memory side counts a strobe one edge after it shows, so let one more edge pass
        issue('0, '0, 16'h0000);
        `CHK(seen[0], n_acc[0], "unit a strobe count")
        `CHK(seen[1], n_acc[1], "unit b strobe count")
        end_sim();
    end
endmodule : tb
